// file: plcs_pkg.sv
/*
 * shared constants, config/status structs and helper functions of the serial port.
 * assumes a single 25 MHz clock with active-low asynchronous reset.
 */
package plcs_pkg;
	localparam int CLK_HZ      = 25_000_000;
	localparam int RATE_4800   = 4800;
	localparam int RATE_9600   = 9600;
	localparam int RATE_19200  = 19200;
	localparam int RATE_38400  = 38400;
	localparam int RATE_57600  = 57600;
	localparam int RATE_115200 = 115200;
	localparam int MSG_MAX     = 1024;
	localparam int TURN_MS     = 5;
	localparam int TURN_CYC    = (CLK_HZ / 1000) * TURN_MS;
	localparam int GAP_BITS    = 40;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [3:0]  FRAME_BITS_PAR = 4'hb;
	localparam logic [3:0]  FRAME_BITS     = 4'ha;

	typedef struct packed {
		logic       enable;
		logic       rs485;
		logic       modbus;
		logic       parity_en;
		logic       parity_odd;
		logic [2:0] baud_sel;
	} plcs_cfg_s;

	typedef struct packed {
		logic parity;
		logic frame;
		logic overrun;
	} plcs_char_err_s;

	typedef struct packed {
		logic sum;
		logic too_long;
	} plcs_msg_err_s;

	function automatic logic [12:0] plcs_bit_cycles(input logic [2:0] sel);
		case (sel)
			3'h0: return 13'(CLK_HZ / RATE_4800);
			3'h1: return 13'(CLK_HZ / RATE_9600);
			3'h2: return 13'(CLK_HZ / RATE_19200);
			3'h3: return 13'(CLK_HZ / RATE_38400);
			3'h4: return 13'(CLK_HZ / RATE_57600);
			default: return 13'(CLK_HZ / RATE_115200);
		endcase
	endfunction

	function automatic logic [15:0] plcs_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// file: plcs_tx.sv
/*
 * character transmitter: start bit, eight data bits lsb first, optional parity, one stop bit.
 * assumes bit_cyc stays stable while a character is on the line.
 */
module plcs_tx import plcs_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [12:0] bit_cyc,
	input  wire logic        parity_en,
	input  wire logic        parity_odd,
	input  wire logic        valid,
	input  wire logic [7:0]  data,
	output logic             ready,
	output logic             busy,
	output logic             txd
);
	logic [10:0] shreg_q, shreg_d;
	logic [3:0]  bits_q, bits_d;
	logic [12:0] div_q, div_d;

	always_comb begin
		shreg_d = shreg_q;
		bits_d  = bits_q;
		div_d   = div_q;
		if (bits_q == 4'h0) begin
			if (valid) begin
				// line idles high, so the frame register is padded with ones
				shreg_d = parity_en ? {1'b1, ^data ^ parity_odd, data, 1'b0}
				                    : {2'b11, data, 1'b0};
				bits_d  = parity_en ? FRAME_BITS_PAR : FRAME_BITS;
				div_d   = bit_cyc - 13'h1;
			end
		end else if (div_q == 13'h0) begin
			shreg_d = {1'b1, shreg_q[10:1]};
			bits_d  = bits_q - 4'h1;
			div_d   = bit_cyc - 13'h1;
		end else begin
			div_d = div_q - 13'h1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shreg_q <= 11'h7ff;
			bits_q  <= 4'h0;
			div_q   <= 13'h0;
		end else begin
			shreg_q <= shreg_d;
			bits_q  <= bits_d;
			div_q   <= div_d;
		end
	end

	assign busy  = bits_q != 4'h0;
	assign ready = !busy;
	assign txd   = shreg_q[0];
endmodule

// file: plcs_rx.sv
/*
 * character receiver sampling each bit at its middle; reports parity and framing errors.
 * assumes line is already synchronised to mclk and idles high.
 */
module plcs_rx import plcs_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [12:0] bit_cyc,
	input  wire logic        parity_en,
	input  wire logic        parity_odd,
	input  wire logic        en,
	input  wire logic        line,
	output logic             busy,
	output logic             done,
	output logic [7:0]       data,
	output logic             perr,
	output logic             ferr
);
	logic        act_q, act_d;
	logic [3:0]  idx_q, idx_d;
	logic [12:0] div_q, div_d;
	logic [8:0]  sh_q, sh_d;
	logic        done_q, done_d, perr_q, perr_d, ferr_q, ferr_d;
	logic [3:0]  stop_idx;

	assign stop_idx = parity_en ? 4'ha : 4'h9;

	always_comb begin
		act_d  = act_q;
		idx_d  = idx_q;
		div_d  = div_q;
		sh_d   = sh_q;
		done_d = 1'b0;
		perr_d = perr_q;
		ferr_d = ferr_q;
		if (!act_q) begin
			if (en && !line) begin
				act_d = 1'b1;
				idx_d = 4'h0;
				div_d = {1'b0, bit_cyc[12:1]};
			end
		end else if (div_q != 13'h0) begin
			div_d = div_q - 13'h1;
		end else begin
			div_d = bit_cyc - 13'h1;
			idx_d = idx_q + 4'h1;
			if (idx_q == 4'h0) begin
				// a glitch shorter than half a bit is not a start bit
				act_d = !line;
			end else if (idx_q == stop_idx) begin
				act_d  = 1'b0;
				done_d = 1'b1;
				ferr_d = !line;
				perr_d = parity_en && (^sh_q ^ parity_odd);
			end else begin
				sh_d = parity_en ? {line, sh_q[8:1]} : {1'b0, line, sh_q[7:1]};
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			act_q  <= 1'b0;
			idx_q  <= 4'h0;
			div_q  <= 13'h0;
			sh_q   <= 9'h000;
			done_q <= 1'b0;
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
		end else begin
			act_q  <= act_d;
			idx_q  <= idx_d;
			div_q  <= div_d;
			sh_q   <= sh_d;
			done_q <= done_d;
			perr_q <= perr_d;
			ferr_q <= ferr_d;
		end
	end

	assign busy = act_q;
	assign done = done_q;
	// both shift paths leave d0 in bit 0; the parity bit, when present, sits above the byte
	assign data = sh_q[7:0];
	assign perr = perr_q;
	assign ferr = ferr_q;
endmodule

// file: plcs_port.sv
/*
 * half-duplex serial port: rs-232c or rs-422/485 pins, message framing by line silence,
 * sum check (byte sum or crc-16), length and character error flags, rs-485 turnaround.
 * assumes cfg is held stable while traffic is in progress; user side runs on mclk.
 */
module plcs_port import plcs_pkg::*; #(
	parameter int TURN_CYCLES = TURN_CYC
) (
	input  wire logic           mclk,
	input  wire logic           rstn,
	input  wire plcs_cfg_s      cfg,
	input  wire logic           tx_valid,
	input  wire logic [7:0]     tx_data,
	input  wire logic           tx_last,
	output logic                tx_ready,
	output logic                tx_overlong,
	output logic                rx_valid,
	output logic [7:0]          rx_data,
	output plcs_char_err_s      rx_err,
	input  wire logic           rx_ready,
	output logic                msg_done,
	output plcs_msg_err_s       msg_err,
	output logic                carrier_present,
	output logic                serial_out,
	input  wire logic           serial_in,
	input  wire logic           peer_ready_in,
	input  wire logic           carrier_detect_in,
	output logic                cpu_link_ready,
	output logic                fixed_high_ready,
	output logic                cpu_recv_ready,
	output logic                send_pair_pos,
	output logic                send_pair_neg,
	output logic                send_pair_oe,
	input  wire logic           recv_pair_pos,
	input  wire logic           recv_pair_neg
);
	localparam int TW = $clog2(TURN_CYCLES + 1);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SEND  = 3'b010,
		ST_DRAIN = 3'b100
	} plcs_tx_state_e;

	// pin synchronisers: only the second stage is read
	logic [4:0] sync_a_q, sync_b_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_a_q <= 5'h1f;
			sync_b_q <= 5'h1f;
		end else begin
			sync_a_q <= {serial_in, recv_pair_pos, recv_pair_neg, peer_ready_in, carrier_detect_in};
			sync_b_q <= sync_a_q;
		end
	end

	logic rxd_s, pos_s, neg_s, peer_s, cd_s, rx_line;
	assign {rxd_s, pos_s, neg_s, peer_s, cd_s} = sync_b_q;
	// undefined differential state (both equal) reads as idle mark
	assign rx_line = cfg.rs485 ? ((pos_s != neg_s) ? pos_s : 1'b1) : rxd_s;

	logic [12:0] bit_cyc;
	logic [18:0] gap_len;
	assign bit_cyc = plcs_bit_cycles(cfg.baud_sel);
	assign gap_len = 19'(bit_cyc * 19'(GAP_BITS));

	logic       core_valid, core_ready, core_busy, txd;
	logic       rx_busy, rx_done, rx_perr, rx_ferr;
	logic [7:0] rx_byte;
	plcs_tx_state_e st_q, st_d;

	plcs_tx u_tx (
		.mclk       (mclk),
		.rstn       (rstn),
		.bit_cyc    (bit_cyc),
		.parity_en  (cfg.parity_en),
		.parity_odd (cfg.parity_odd),
		.valid      (core_valid),
		.data       (tx_data),
		.ready      (core_ready),
		.busy       (core_busy),
		.txd        (txd)
	);

	plcs_rx u_rx (
		.mclk       (mclk),
		.rstn       (rstn),
		.bit_cyc    (bit_cyc),
		.parity_en  (cfg.parity_en),
		.parity_odd (cfg.parity_odd),
		.en         (cfg.enable && st_q == ST_IDLE && !core_busy),
		.line       (rx_line),
		.busy       (rx_busy),
		.done       (rx_done),
		.data       (rx_byte),
		.perr       (rx_perr),
		.ferr       (rx_ferr)
	);

	// receive holding register and message check
	logic           rxv_q, rxv_d;
	logic [7:0]     rxb_q, rxb_d;
	plcs_char_err_s rxe_q, rxe_d;
	logic           in_msg_q, in_msg_d, mdone_q, mdone_d;
	plcs_msg_err_s  merr_q, merr_d;
	logic [18:0]    gap_q, gap_d;
	logic [10:0]    cnt_q, cnt_d;
	logic [7:0]     body_q, body_d, last_q, last_d;
	logic [15:0]    crc_q, crc_d;

	always_comb begin
		rxv_d    = rxv_q;
		rxb_d    = rxb_q;
		rxe_d    = rxe_q;
		in_msg_d = in_msg_q;
		mdone_d  = 1'b0;
		merr_d   = merr_q;
		gap_d    = gap_q;
		cnt_d    = cnt_q;
		body_d   = body_q;
		last_d   = last_q;
		crc_d    = crc_q;
		if (rx_ready) begin
			rxv_d = 1'b0;
		end
		if (rx_done) begin
			// a new character beats the user's take in the same cycle
			rxv_d  = 1'b1;
			rxb_d  = rx_byte;
			rxe_d  = '{parity: rx_perr, frame: rx_ferr, overrun: rxv_q && !rx_ready};
			gap_d  = 19'h0;
			in_msg_d = 1'b1;
			cnt_d  = in_msg_q ? ((cnt_q > 11'(MSG_MAX)) ? cnt_q : cnt_q + 11'h1) : 11'h1;
			body_d = in_msg_q ? body_q + last_q : 8'h00;
			last_d = rx_byte;
			crc_d  = plcs_crc_step(in_msg_q ? crc_q : CRC_INIT, rx_byte);
		end else if (in_msg_q && !rx_busy) begin
			if (gap_q >= gap_len) begin
				// silence ends the message; modbus residue is zero when the crc matches
				in_msg_d = 1'b0;
				mdone_d  = 1'b1;
				merr_d.sum      = cfg.modbus ? (crc_q != 16'h0000) : (body_q != last_q);
				merr_d.too_long = cnt_q > 11'(MSG_MAX);
			end else begin
				gap_d = gap_q + 19'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rxv_q    <= 1'b0;
			rxb_q    <= 8'h00;
			rxe_q    <= '0;
			in_msg_q <= 1'b0;
			mdone_q  <= 1'b0;
			merr_q   <= '0;
			gap_q    <= 19'h0;
			cnt_q    <= 11'h0;
			body_q   <= 8'h00;
			last_q   <= 8'h00;
			crc_q    <= CRC_INIT;
		end else begin
			rxv_q    <= rxv_d;
			rxb_q    <= rxb_d;
			rxe_q    <= rxe_d;
			in_msg_q <= in_msg_d;
			mdone_q  <= mdone_d;
			merr_q   <= merr_d;
			gap_q    <= gap_d;
			cnt_q    <= cnt_d;
			body_q   <= body_d;
			last_q   <= last_d;
			crc_q    <= crc_d;
		end
	end

	// transmit control: half duplex, peer handshake, turnaround, length limit
	logic          peer_ok, turn_ok, start_ok, accept;
	logic [TW-1:0] turn_q, turn_d;
	logic [10:0]   tcnt_q, tcnt_d;
	logic          tol_q, tol_d;

	assign peer_ok  = cfg.rs485 || peer_s;
	assign turn_ok  = !cfg.rs485 || turn_q == TW'(TURN_CYCLES);
	assign start_ok = cfg.enable && tx_valid && !rx_busy && !rx_done && !in_msg_q && turn_ok && peer_ok;
	assign tx_ready = st_q == ST_SEND && peer_ok && (core_ready || tcnt_q >= 11'(MSG_MAX));
	assign accept   = tx_valid && tx_ready;
	// bytes beyond the limit are swallowed rather than sent, so the peer never sees them
	assign core_valid = st_q == ST_SEND && tx_valid && peer_ok && tcnt_q < 11'(MSG_MAX);

	always_comb begin
		st_d   = st_q;
		tcnt_d = tcnt_q;
		tol_d  = tol_q;
		turn_d = rx_done ? '0 : (turn_q == TW'(TURN_CYCLES) ? turn_q : turn_q + TW'(1));
		case (st_q)
			ST_IDLE: begin
				if (start_ok) begin
					st_d   = ST_SEND;
					tcnt_d = 11'h0;
					tol_d  = 1'b0;
				end
			end
			ST_SEND: begin
				if (accept) begin
					tcnt_d = (tcnt_q >= 11'(MSG_MAX)) ? tcnt_q : tcnt_q + 11'h1;
					tol_d  = tol_q || tcnt_q >= 11'(MSG_MAX);
					if (tx_last) begin
						st_d = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				if (!core_busy) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q   <= ST_IDLE;
			turn_q <= TW'(TURN_CYCLES);
			tcnt_q <= 11'h0;
			tol_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			turn_q <= turn_d;
			tcnt_q <= tcnt_d;
			tol_q  <= tol_d;
		end
	end

	// registered pins
	logic sout_q, pos_q, oe_q, link_q, rr_q, cd_q;
	logic sout_d, pos_d, oe_d, link_d, rr_d;

	always_comb begin
		sout_d = cfg.rs485 ? 1'b1 : txd;
		pos_d  = cfg.rs485 ? txd : 1'b1;
		oe_d   = cfg.rs485 && (st_q != ST_IDLE || core_busy);
		link_d = cfg.enable && !cfg.rs485;
		rr_d   = cfg.enable && !cfg.rs485 && !rxv_q && st_q == ST_IDLE && !core_busy;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sout_q <= 1'b1;
			pos_q  <= 1'b1;
			oe_q   <= 1'b0;
			link_q <= 1'b0;
			rr_q   <= 1'b0;
			cd_q   <= 1'b0;
		end else begin
			sout_q <= sout_d;
			pos_q  <= pos_d;
			oe_q   <= oe_d;
			link_q <= link_d;
			rr_q   <= rr_d;
			cd_q   <= cd_s;
		end
	end

	assign serial_out       = sout_q;
	assign send_pair_pos    = pos_q;
	assign send_pair_neg    = !pos_q;
	assign send_pair_oe     = oe_q;
	assign cpu_link_ready   = link_q;
	assign fixed_high_ready = 1'b1;
	assign cpu_recv_ready   = rr_q;
	assign carrier_present  = cd_q;
	assign tx_overlong      = tol_q;
	assign rx_valid         = rxv_q;
	assign rx_data          = rxb_q;
	assign rx_err           = rxe_q;
	assign msg_done         = mdone_q;
	assign msg_err          = merr_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	AST_RATE_FASTEST: assert property (cfg.baud_sel == 3'h5 |-> bit_cyc == 13'd217)
		else $error("115200 setting does not give 217 cycles per bit");
	property p_lsb_first;
		logic [7:0] first_b;
		(core_valid && core_ready && bit_cyc == 13'd217, first_b = tx_data)
		|-> ##1 !txd ##300 txd == first_b[0];
	endproperty
	AST_LSB_FIRST: assert property (p_lsb_first)
		else $error("first data bit on line is not the lsb");
	AST_FRAME_FLAG: assert property (rx_done && rx_ferr |=> rx_valid && rx_err.frame)
		else $error("framing error not reported");
	AST_OVERRUN: assert property (rx_done && rxv_q && !rx_ready |=> rx_err.overrun)
		else $error("overrun not reported");
	AST_TOO_LONG: assert property (
		in_msg_q && !rx_done && !rx_busy && gap_q >= gap_len && cnt_q > 11'(MSG_MAX)
		|=> msg_done && msg_err.too_long)
		else $error("overlong message not flagged");
	AST_LINK_READY: assert property (cfg.enable && !cfg.rs485 |=> cpu_link_ready)
		else $error("link ready low while able to communicate");
	AST_RECV_READY: assert property (rxv_q |=> !cpu_recv_ready)
		else $error("receive ready high while holding register is full");
	AST_PEER_LOW: assert property (!cfg.rs485 && !peer_s |-> !core_valid && !tx_ready)
		else $error("transmission started with peer not ready");
	AST_TURNAROUND: assert property (st_q == ST_IDLE && st_d == ST_SEND && cfg.rs485
		|-> turn_q == TW'(TURN_CYCLES))
		else $error("rs-485 send before turnaround time elapsed");
	AST_HALF_DUPLEX: assert property (core_busy |-> !rx_busy)
		else $error("receiver active while transmitting");
	AST_DRIVER_OFF: assert property (st_q == ST_IDLE && !core_busy |=> !send_pair_oe)
		else $error("rs-485 driver enabled while idle");
	AST_IDLE_MARK: assert property (!core_busy && st_q == ST_IDLE |-> txd)
		else $error("line not idle high");

	COV_GOOD_MSG: cover property (msg_done && !msg_err.sum && !msg_err.too_long);
	COV_TX_MSG: cover property (st_q == ST_DRAIN ##1 st_q == ST_IDLE);
	COV_OVERRUN: cover property (rx_valid && rx_err.overrun);
endmodule

// file: plcs_peer_model.sv
/*
 * far-side serial peer: sends start-stop characters on demand and decodes what it hears.
 * assumes one mclk; the bench picks which line it listens to and calls send_char.
 */
module plcs_peer_model import plcs_pkg::*; #(
	parameter int BIT = CLK_HZ / RATE_115200
) (
	input  wire logic       mclk,
	input  wire logic       line_in,
	input  wire logic       par_en,
	input  wire logic       par_odd,
	output logic            line_out,
	output logic            got_valid,
	output logic [7:0]      got_data,
	output logic            got_perr,
	output logic            got_ferr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		line_out = 1'b1;
		got_valid = 1'b0;
		got_data = 8'h00;
		got_perr = 1'b0;
		got_ferr = 1'b0;
	end

	// bad_par flips the parity bit; bad_stop holds the stop bit low for three quarters
	// of a bit, so a receiver sees the framing fault at mid-bit and drops the tail as a glitch
	task automatic send_char(input logic [7:0] b, input logic bad_par, input logic bad_stop = 1'b0);
		logic [10:0] f;
		f = {!bad_stop, ^b ^ par_odd ^ bad_par, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i != 9 || par_en) begin
				@(negedge mclk);
				line_out = f[i];
				repeat ((i == 10 && bad_stop) ? BIT * 3 / 4 : BIT - 1) @(negedge mclk);
			end
		end
		line_out = 1'b1;
	endtask

	// sample each bit at its middle, as a real receiver at the same rate would
	always begin
		logic [10:0] s;
		int          n;
		@(negedge mclk);
		got_valid = 1'b0;
		if (line_in === 1'b0) begin
			n = par_en ? 11 : 10;
			repeat (BIT / 2) @(negedge mclk);
			for (int i = 0; i < n; i++) begin
				s[i] = line_in;
				if (i < n - 1)
					repeat (BIT) @(negedge mclk);
			end
			got_data = s[8:1];
			got_perr = par_en && (s[9] !== (^s[8:1] ^ par_odd));
			got_ferr = (s[0] !== 1'b0) || (s[n - 1] !== 1'b1);
			got_valid = 1'b1;
		end
	end
endmodule

// file: testbench.sv
/*
 * self-checking bench for the serial port: rs-232c and rs-485 send and receive, sum and crc.
 * assumes the peer model at the far side and the port's 115200 rate setting.
 */
module testbench import plcs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic             mclk, rstn, tx_valid, tx_last, rx_ready, peer_ready_in, carrier_detect_in;
	logic [7:0]       tx_data, rx_data, got_data, b0, b1;
	plcs_cfg_s        cfg;
	plcs_char_err_s   rx_err;
	plcs_msg_err_s    msg_err;
	logic             tx_ready, tx_overlong, rx_valid, msg_done, carrier_present, serial_out;
	logic             cpu_link_ready, fixed_high_ready, cpu_recv_ready;
	logic             send_pair_pos, send_pair_neg, send_pair_oe;
	logic             peer_line, peer_rx_line, got_valid, got_perr, got_ferr;
	logic [15:0]      rnd, crc;
	logic [9:0]       txq[$];
	logic [10:0]      rxq[$];
	logic [1:0]       msgq[$];
	int               failures = 0;
	int               num_checks = 0;

	// a released rs-485 pair is biased to mark
	assign peer_rx_line = cfg.rs485 ? (send_pair_oe ? send_pair_pos : 1'b1) : serial_out;

	plcs_port #(.TURN_CYCLES(50)) DUT (.mclk(mclk), .rstn(rstn), .cfg(cfg), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_overlong(tx_overlong),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rx_ready(rx_ready),
		.msg_done(msg_done), .msg_err(msg_err), .carrier_present(carrier_present),
		.serial_out(serial_out), .serial_in(peer_line), .peer_ready_in(peer_ready_in),
		.carrier_detect_in(carrier_detect_in), .cpu_link_ready(cpu_link_ready),
		.fixed_high_ready(fixed_high_ready), .cpu_recv_ready(cpu_recv_ready),
		.send_pair_pos(send_pair_pos), .send_pair_neg(send_pair_neg),
		.send_pair_oe(send_pair_oe), .recv_pair_pos(peer_line), .recv_pair_neg(~peer_line));

	plcs_peer_model peer (.mclk(mclk), .line_in(peer_rx_line), .par_en(cfg.parity_en),
		.par_odd(cfg.parity_odd), .line_out(peer_line), .got_valid(got_valid),
		.got_data(got_data), .got_perr(got_perr), .got_ferr(got_ferr));

	always #20 mclk = ~mclk;

	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
			failures++;
		end
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic bound_out;
		$display("Error %0t: wait ran out", $time);
		failures++;
		summarize();
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] r);
		return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
	endfunction

	task automatic next_byte(output logic [7:0] b);
		rnd = lfsr_next(rnd);
		b = rnd[7:0];
	endtask

	// leaves tx_valid high so back-to-back bytes never toggle it within one step
	task automatic send_byte(input logic [7:0] b, input logic last);
		int n;
		tx_valid = 1'b1;
		tx_data = b;
		tx_last = last;
		txq.push_back({2'b00, b});
		for (n = 0; n < 6000; n++) begin
			#1;
			if (tx_ready === 1'b1)
				break;
			@(negedge mclk);
		end
		if (n == 6000)
			bound_out();
		@(negedge mclk);
	endtask

	task automatic drain(input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(negedge mclk);
			if (txq.size() == 0 && rxq.size() == 0 && msgq.size() == 0)
				break;
		end
		if (n == lim)
			bound_out();
	endtask

	always @(posedge mclk) begin
		if (got_valid === 1'b1) begin
			if (txq.size() == 0)
				chk(1'b1, 1'b0, "unexpected line character");
			else
				chk({got_perr, got_ferr, got_data}, txq.pop_front(), "line character");
		end
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (rxq.size() == 0)
				chk(1'b1, 1'b0, "unexpected received byte");
			else
				chk({rx_err, rx_data}, rxq.pop_front(), "received byte");
		end
		if (msg_done === 1'b1) begin
			if (msgq.size() == 0)
				chk(1'b1, 1'b0, "unexpected message end");
			else
				chk(msg_err, msgq.pop_front(), "message check");
		end
	end

	initial begin
		repeat (100000) @(posedge mclk);
		bound_out();
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		rnd = 16'hbf55;
		cfg = '{enable: 1'b1, rs485: 1'b0, modbus: 1'b0, parity_en: 1'b1, parity_odd: 1'b1,
			baud_sel: 3'h5};
		tx_valid = 1'b0;
		tx_data = 8'h00;
		tx_last = 1'b0;
		rx_ready = 1'b1;
		peer_ready_in = 1'b0;
		carrier_detect_in = 1'b0;
		repeat (10) @(negedge mclk);
		chk(serial_out, 1'b1, "line idle in reset");
		chk(send_pair_oe, 1'b0, "driver off in reset");
		chk(fixed_high_ready, 1'b1, "fixed ready");
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		carrier_detect_in = 1'b1;
		repeat (5) @(negedge mclk);
		chk(cpu_link_ready, 1'b1, "link ready");
		chk(cpu_recv_ready, 1'b1, "receive ready");
		chk(carrier_present, 1'b1, "carrier");
		$display("test reset done");

		next_byte(b0);
		tx_data = b0;
		tx_valid = 1'b1;
		repeat (30) @(negedge mclk);
		chk(tx_ready, 1'b0, "stall while peer not ready");
		chk(serial_out, 1'b1, "no send while peer not ready");
		peer_ready_in = 1'b1;
		send_byte(b0, 1'b0);
		next_byte(b1);
		send_byte(b1, 1'b0);
		repeat (1000) @(negedge mclk);
		chk(cpu_recv_ready, 1'b0, "not receive ready while sending");
		chk(send_pair_oe, 1'b0, "pair idle in rs-232c");
		send_byte(8'(b0 ^ b1), 1'b1);
		tx_valid = 1'b0;
		drain(8000);
		// the peer hears mid-stop; the port ignores its input until that stop bit is out
		repeat (300) @(negedge mclk);
		$display("test send rs-232c done");

		rxq.push_back({3'b000, b0});
		rxq.push_back({3'b000, b1});
		rxq.push_back({3'b000, 8'(b0 + b1)});
		msgq.push_back(2'b00);
		peer.send_char(b0, 1'b0);
		peer.send_char(b1, 1'b0);
		peer.send_char(8'(b0 + b1), 1'b0);
		drain(12000);
		$display("test receive sum done");

		// a held byte blocking receive-ready, an overrun, then parity and framing faults
		rx_ready = 1'b0;
		rxq.push_back({3'b001, b1});
		rxq.push_back({3'b100, b0});
		rxq.push_back({3'b010, b1});
		msgq.push_back({8'(b0 + b1 + b0) != b1, 1'b0});
		peer.send_char(b0, 1'b0);
		repeat (20) @(negedge mclk);
		chk(cpu_recv_ready, 1'b0, "not receive ready while holding");
		peer.send_char(b1, 1'b0);
		repeat (20) @(negedge mclk);
		rx_ready = 1'b1;
		peer.send_char(b0, 1'b1);
		peer.send_char(b1, 1'b0, 1'b1);
		drain(12000);
		$display("test receive errors done");

		cfg.modbus = 1'b1;
		cfg.parity_en = 1'b0;
		crc = crc_add(crc_add(CRC_INIT, b0), b1);
		rxq.push_back({3'b000, b0});
		rxq.push_back({3'b000, b1});
		rxq.push_back({3'b000, crc[7:0]});
		rxq.push_back({3'b000, crc[15:8]});
		msgq.push_back(2'b00);
		peer.send_char(b0, 1'b0);
		peer.send_char(b1, 1'b0);
		peer.send_char(crc[7:0], 1'b0);
		peer.send_char(crc[15:8], 1'b0);
		drain(14000);
		$display("test receive crc done");

		cfg.modbus = 1'b0;
		cfg.rs485 = 1'b1;
		repeat (5) @(negedge mclk);
		chk(cpu_link_ready, 1'b0, "link ready off in rs-485");
		chk(cpu_recv_ready, 1'b0, "receive ready off in rs-485");
		next_byte(b0);
		send_byte(b0, 1'b1);
		tx_valid = 1'b0;
		repeat (1000) @(negedge mclk);
		chk(send_pair_oe, 1'b1, "driver on while sending");
		chk(send_pair_neg, !send_pair_pos, "pair is differential");
		chk(serial_out, 1'b1, "rs-232c line quiet");
		drain(3000);
		repeat (200) @(negedge mclk);
		chk(send_pair_oe, 1'b0, "driver released");
		next_byte(b1);
		rxq.push_back({3'b000, b1});
		msgq.push_back({b1 != 8'h00, 1'b0});
		peer.send_char(b1, 1'b0);
		drain(12000);
		chk(tx_overlong, 1'b0, "no overlong message");
		$display("test rs-485 done");
		summarize();
	end
endmodule
